// File: design/node_cfg_pkg.sv
// Types shared by the node configuration select block.
// Assumes the constants header sits beside it.
package node_cfg_pkg;

   // Resolved serial settings
   typedef struct packed {
      logic [5:0] node_addr;
      logic [1:0] rate_code;
   } serial_cfg_t;

   // Loader states, Gray coded along the path
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_FETCH = 2'b01,
      ST_LATCH = 2'b11,
      ST_HOLD = 2'b10
   } load_state_t;

endpackage

// File: design/node_cfg_regs.svh
// Offsets, field positions, reset values and bit rates for the node configuration block.
// Assumes inclusion by bare name from the design modules, the checker and the bench.
`ifndef NODE_CFG_REGS_SVH
`define NODE_CFG_REGS_SVH

// Register byte offsets
`define REG_SWITCH_OFS 12'h000
`define REG_ACTIVE_OFS 12'h004
`define REG_NVM_OFS 12'h008
`define REG_CTRL_OFS 12'h00c
`define REG_STATUS_OFS 12'h010
`define REG_RATE_OFS 12'h014

// Switch field positions within the switch bank
`define SW_ADDR_LSB 0
`define SW_ADDR_MSB 5
`define SW_RATE_LSB 6
`define SW_RATE_MSB 7

// Field positions
`define ADDR_LSB 0
`define ADDR_MSB 5
`define RATE_LSB 8
`define RATE_MSB 9
`define CTRL_STO_DIS_BIT 0
`define STAT_LOADED_BIT 0
`define STAT_MULTI_BIT 1
`define STAT_STO_OK_BIT 2
`define STAT_RUN_BIT 3
`define STAT_ADDR_NVM_BIT 4
`define STAT_RATE_NVM_BIT 5

// Reset values
`define NVM_ADDR_RST 6'h01
`define NVM_RATE_RST 2'h1
`define CTRL_RST 1'h0

// Bit rates in bits per second for each nonzero rate code
`define RATE_CODE1_BPS 32'h00002580
`define RATE_CODE2_BPS 32'h00009600
`define RATE_CODE3_BPS 32'h0001c200

// Codes
`define ZERO_ADDR 6'h00
`define ZERO_RATE 2'h0

`endif

// File: design/rate_decode.sv
// Maps a 2-bit rate code to a bit rate in bits per second.
// Assumes a nonzero code; code zero yields zero.
`timescale 1ns/100ps
`include "node_cfg_regs.svh"

module rate_decode (
   // Code in
   input wire logic [1:0] rate_code,
   // Rate out
   output logic [31:0] rate_bps
);

   // Code table
   assign rate_bps = (rate_code == 2'h1) ? `RATE_CODE1_BPS :
                     (rate_code == 2'h2) ? `RATE_CODE2_BPS :
                     (rate_code == 2'h3) ? `RATE_CODE3_BPS :
                     32'h00000000;

endmodule

// File: design/serial_node_config_select.sv
// Serial node address and bit-rate selection from switches with stored fallback.
// Assumes synchronous switch, mode and safety inputs, and an APB master on clk.
`timescale 1ns/100ps
`include "node_cfg_regs.svh"

// Summary of operation
// - Switches 1-6 form node address, switch 1 LSB
// - Switches 7-8 form rate code, switch 7 LSB
// - Zero field selects stored value, independently
// - Codes 1,2,3 give 9.6, 38.4, 115.2 kbps
// - Switches apply only in multi-drop mode
// - Drive runs only if safety satisfied or disabled
module serial_node_config_select (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Hardware settings
   input wire logic [7:0] switch_in,
   input wire logic mode_select_n,
   input wire logic sto_in1,
   input wire logic sto_in2,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Resolved outputs
   output node_cfg_pkg::serial_cfg_t active_cfg,
   output logic [31:0] bit_rate_bps,
   output logic multi_drop,
   output logic cfg_loaded,
   output logic drive_enable
);

   // Loader state
   node_cfg_pkg::load_state_t state_reg, state_next;
   // Stored fallback values, writable by software
   logic [5:0] nvm_addr_reg;
   logic [1:0] nvm_rate_reg;
   // Switch snapshot
   // Taken once per reset, so later switch moves are ignored
   logic [7:0] switch_reg;
   // Snapshot of the mode strap
   logic multi_reg;
   // Software safety disable
   logic sto_dis_reg;
   // Resolved settings and their source
   node_cfg_pkg::serial_cfg_t cfg_reg, cfg_next;
   logic addr_nvm_reg, rate_nvm_reg;
   // Readback data flop
   logic [31:0] rdata_reg, rdata_next;
   // Decoded rate of the active code, flopped before it leaves
   logic [31:0] rate_bps;

   // Switch fields from the snapshot: on contributes a one
   // The zero test reads the snapshot too, so a switch moved during the load
   // cannot split the fallback decision from the value that is applied
   wire [5:0] sw_addr = switch_reg[`SW_ADDR_MSB:`SW_ADDR_LSB];
   wire [1:0] sw_rate = switch_reg[`SW_RATE_MSB:`SW_RATE_LSB];
   // Ground on the select pin means multi-drop
   wire multi_now = ~mode_select_n;
   wire use_nvm_addr = (sw_addr == `ZERO_ADDR) || !multi_reg;
   wire use_nvm_rate = (sw_rate == `ZERO_RATE) || !multi_reg;

   // Bus decode
   // Full-word address compares, so aliases of a register read as unmapped
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire hit_switch = (paddr == `REG_SWITCH_OFS);
   wire hit_active = (paddr == `REG_ACTIVE_OFS);
   wire hit_nvm = (paddr == `REG_NVM_OFS);
   wire hit_ctrl = (paddr == `REG_CTRL_OFS);
   wire hit_status = (paddr == `REG_STATUS_OFS);
   wire hit_rate = (paddr == `REG_RATE_OFS);
   wire hit_any = hit_switch | hit_active | hit_nvm | hit_ctrl | hit_status | hit_rate;
   // Stored values change on any write; only writes before the latch are used
   wire nvm_wr = wr && hit_nvm;
   wire ctrl_wr = wr && hit_ctrl;
   // Safety gate: both inputs asserted, or feature disabled
   // An open or failed safety input reads low and stops the drive
   wire sto_ok = sto_in1 && sto_in2;
   wire run_ok = cfg_loaded && (sto_ok || sto_dis_reg);

   // Rate lookup
   // Pure table; code zero gives a zero rate
   rate_decode u_rate (
      .rate_code(cfg_reg.rate_code),
      .rate_bps(rate_bps)
   );

   // Loader sequencing: snapshot switches in fetch, resolve settings in latch, then hold
   // One pass per reset; only a reset leaves the hold state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         node_cfg_pkg::ST_RESET: state_next = node_cfg_pkg::ST_FETCH;
         node_cfg_pkg::ST_FETCH: state_next = node_cfg_pkg::ST_LATCH;
         node_cfg_pkg::ST_LATCH: state_next = node_cfg_pkg::ST_HOLD;
         default: state_next = node_cfg_pkg::ST_HOLD;
      endcase
   end

   // Resolution of each field on its own
   always_comb begin
      cfg_next = cfg_reg;
      // Only the latch state changes anything; elsewhere the value holds
      if (state_reg == node_cfg_pkg::ST_LATCH) begin
         // Zero field or point-to-point mode takes the stored value
         cfg_next.node_addr = use_nvm_addr ? nvm_addr_reg : sw_addr;
         cfg_next.rate_code = use_nvm_rate ? nvm_rate_reg : sw_rate;
      end
   end

   // Readback mux, decoded from the setup-cycle address
   // Flopping it costs a cycle of latency but keeps the access phase clean
   always_comb begin
      // Unmapped addresses and unused bits read zero
      rdata_next = 32'h00000000;
      if (hit_switch) begin
         rdata_next[`SW_RATE_MSB:`SW_ADDR_LSB] = switch_reg;
      end else if (hit_active) begin
         rdata_next[`ADDR_MSB:`ADDR_LSB] = cfg_reg.node_addr;
         rdata_next[`RATE_MSB:`RATE_LSB] = cfg_reg.rate_code;
      end else if (hit_nvm) begin
         rdata_next[`ADDR_MSB:`ADDR_LSB] = nvm_addr_reg;
         rdata_next[`RATE_MSB:`RATE_LSB] = nvm_rate_reg;
      end else if (hit_ctrl) begin
         rdata_next[`CTRL_STO_DIS_BIT] = sto_dis_reg;
      end else if (hit_status) begin
         rdata_next[`STAT_LOADED_BIT] = cfg_loaded;
         rdata_next[`STAT_MULTI_BIT] = multi_reg;
         rdata_next[`STAT_STO_OK_BIT] = sto_ok;
         rdata_next[`STAT_RUN_BIT] = drive_enable;
         rdata_next[`STAT_ADDR_NVM_BIT] = addr_nvm_reg;
         rdata_next[`STAT_RATE_NVM_BIT] = rate_nvm_reg;
      end else if (hit_rate) begin
         rdata_next = bit_rate_bps;
      end
   end

   // State and snapshots
   // Everything here freezes while the clock enable is low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= node_cfg_pkg::ST_RESET;
         switch_reg <= 8'h00;
         multi_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         // Switches taken once, in the fetch state, one cycle before the latch state
         if (state_reg == node_cfg_pkg::ST_FETCH) begin
            switch_reg <= switch_in;
            multi_reg <= multi_now;
         end
      end
   end

   // Resolved settings, held until the next reset
   // Source flags record which fields fell back to the store
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= '0;
         addr_nvm_reg <= 1'b0;
         rate_nvm_reg <= 1'b0;
         cfg_loaded <= 1'b0;
      end else if (clk_en) begin
         cfg_reg <= cfg_next;
         if (state_reg == node_cfg_pkg::ST_LATCH) begin
            addr_nvm_reg <= use_nvm_addr;
            rate_nvm_reg <= use_nvm_rate;
            cfg_loaded <= 1'b1;
         end
      end
   end

   // Software registers
   // The store is modelled as reset-valued registers, not true retention
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nvm_addr_reg <= `NVM_ADDR_RST;
         nvm_rate_reg <= `NVM_RATE_RST;
         sto_dis_reg <= `CTRL_RST;
      end else if (clk_en) begin
         // Only a write landing before the latch state is used at once;
         // later writes show on readback, and a reset restores the defaults
         if (nvm_wr) begin
            nvm_addr_reg <= pwdata[`ADDR_MSB:`ADDR_LSB];
            nvm_rate_reg <= pwdata[`RATE_MSB:`RATE_LSB];
         end
         if (ctrl_wr) begin
            sto_dis_reg <= pwdata[`CTRL_STO_DIS_BIT];
         end
      end
   end

   // Output flops
   // The rate trails the settings by one cycle, the drive gate its inputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 32'h00000000;
         bit_rate_bps <= 32'h00000000;
         drive_enable <= 1'b0;
      end else if (clk_en) begin
         rdata_reg <= rdata_next;
         bit_rate_bps <= rate_bps;
         drive_enable <= run_ok;
      end
   end

   // Bus answers: no wait states, since read data is flopped from setup
   // Writes to read-only registers are dropped without an error
   assign pready = acc;
   assign pslverr = acc && !hit_any;
   assign prdata = rdata_reg;
   assign active_cfg = cfg_reg;
   assign multi_drop = multi_reg;

endmodule

// File: sim/node_cfg_checker_assertions.sv
// Port checks for the node configuration select block.
// Assumes switches and mode held steady from reset until load.
`timescale 1ns/100ps
`include "node_cfg_regs.svh"
module node_cfg_checker (
   // Clock, reset
   input wire logic clk,
   input wire logic reset_n,
   // Settings in
   input wire logic [7:0] switch_in,
   input wire logic mode_select_n,
   input wire logic sto_in1,
   input wire logic sto_in2,
   // Resolved out
   input wire node_cfg_pkg::serial_cfg_t active_cfg,
   input wire logic [31:0] bit_rate_bps,
   input wire logic multi_drop,
   input wire logic cfg_loaded,
   input wire logic drive_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Snapshot lies two edges before the load flag rises
   addr_from_sw_a: assert property ($rose(cfg_loaded) && !$past(mode_select_n, 2) &&
      $past(switch_in[5:0], 2) != 6'h00 |-> active_cfg.node_addr == $past(switch_in[5:0], 2))
      else $error("node address not from switches");
   rate_from_sw_a: assert property ($rose(cfg_loaded) && !$past(mode_select_n, 2) &&
      $past(switch_in[7:6], 2) != 2'h0 |-> active_cfg.rate_code == $past(switch_in[7:6], 2))
      else $error("rate code not from switches");
   mode_latch_a: assert property ($rose(cfg_loaded) |-> multi_drop == !$past(mode_select_n, 2))
      else $error("mode not latched");
   // Code zero decodes to no rate at all
   rate_decode_a: assert property (cfg_loaded && $past(cfg_loaded) |-> bit_rate_bps ==
      (active_cfg.rate_code == 2'h1 ? `RATE_CODE1_BPS : active_cfg.rate_code == 2'h2 ?
      `RATE_CODE2_BPS : active_cfg.rate_code == 2'h3 ? `RATE_CODE3_BPS : 32'h00000000))
      else $error("bit rate decode wrong");
   cfg_hold_a: assert property (cfg_loaded |=> cfg_loaded && $stable(active_cfg))
      else $error("settings moved after load");
   drive_gate_a: assert property (!cfg_loaded |=> !drive_enable)
      else $error("drive ran before load");
   drive_run_a: assert property (cfg_loaded && sto_in1 && sto_in2 |=> drive_enable)
      else $error("drive held with safety met");
endmodule
bind serial_node_config_select node_cfg_checker chk (.clk, .reset_n, .switch_in,
   .mode_select_n, .sto_in1, .sto_in2, .active_cfg, .bit_rate_bps, .multi_drop,
   .cfg_loaded, .drive_enable);

// File: sim/serial_host_model.sv
// Host side of the serial port: sets the mode select pin.
// Assumes the bench raises multi_req to ask for the multi-drop link.
`timescale 1ns/100ps
module serial_host_model (
   // Request in
   input wire logic multi_req,
   // Pin out, grounded for multi-drop, pulled up when left open
   output logic mode_select_n
);
   assign mode_select_n = multi_req ? 1'b0 : 1'b1;
endmodule

// File: sim/serial_node_config_select_tb.sv
// Self-checking bench for the node configuration select block.
// Assumes a zero-wait APB slave and the host model on the mode pin.
`timescale 1ns/100ps
`include "node_cfg_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module serial_node_config_select_tb;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, multi = 1;
   logic sto_in1 = 0, sto_in2 = 0, mode_select_n, pready, pslverr, multi_drop;
   logic cfg_loaded, drive_enable, err, clk_en = 1;
   logic [7:0] switch_in = 8'h00;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, bit_rate_bps, rdata;
   node_cfg_pkg::serial_cfg_t active_cfg;
   int mismatches = 0, check_count = 0, cyc = 0;
   initial forever #20 clk = ~clk;
   serial_host_model host (.multi_req(multi), .mode_select_n);
   // Clock enable driven by the bench for the freeze test
   serial_node_config_select dut (.clk, .reset_n, .clk_en, .switch_in,
      .mode_select_n, .sto_in1, .sto_in2, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .active_cfg, .bit_rate_bps, .multi_drop,
      .cfg_loaded, .drive_enable);
   // Setup, then access held until ready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Reset with settings held, then wait past the load
   task load(input logic [7:0] sw, input logic m, input int n);
      reset_n <= 1'b0; switch_in <= sw; multi <= m;
      repeat (n) @(posedge clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   function logic [31:0] bps(input logic [1:0] c);
      return c == 2'h1 ? `RATE_CODE1_BPS : c == 2'h2 ? `RATE_CODE2_BPS : `RATE_CODE3_BPS;
   endfunction
   // Every nonzero rate code with a nonzero address
   task t_switch;
      for (int c = 1; c < 4; c++) begin
         load({c[1:0], 6'h25 ^ c[5:0]}, 1'b1, 2);
         `CHK(active_cfg, {6'h25 ^ c[5:0], c[1:0]})
         `CHK(bit_rate_bps, bps(c[1:0]))
         `CHK(multi_drop, 1'b1)
         `CHK(cfg_loaded, 1'b1)
         apb(1'b0, `REG_ACTIVE_OFS, 32'h0);
         `CHK(rdata, {22'h0, c[1:0], 2'h0, 6'h25 ^ c[5:0]})
         `CHK(err, 1'b0)
         apb(1'b0, `REG_RATE_OFS, 32'h0);
         `CHK(rdata, bps(c[1:0]))
      end
      $display("switch test done");
   endtask
   // Zero fields fall back one at a time; later switch moves ignored
   task t_zero;
      load(8'hc0, 1'b1, 2);
      `CHK(active_cfg, {`NVM_ADDR_RST, 2'h3})
      // Status: loaded, multi-drop, address from store, safety not met
      apb(1'b0, `REG_STATUS_OFS, 32'h0);
      `CHK(rdata, 32'h00000013)
      load(8'h05, 1'b1, 2);
      `CHK(active_cfg, {6'h05, `NVM_RATE_RST})
      switch_in <= 8'hff;
      repeat (4) @(posedge clk);
      `CHK(active_cfg, {6'h05, `NVM_RATE_RST})
      $display("zero test done");
   endtask
   // Stored values written in the window before the latch are used
   task t_store;
      reset_n <= 1'b0; switch_in <= 8'h00; multi <= 1'b1;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      psel <= 1'b1; pwrite <= 1'b1; paddr <= `REG_NVM_OFS; pwdata <= 32'h0000022a;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(err, 1'b0)
      `CHK(active_cfg, {6'h2a, 2'h2})
      `CHK(bit_rate_bps, `RATE_CODE2_BPS)
      $display("store test done");
   endtask
   // Clock enable low holds the loader still after reset
   task t_freeze;
      clk_en <= 1'b0;
      load(8'h9c, 1'b1, 2);
      `CHK(cfg_loaded, 1'b0)
      `CHK(active_cfg, 8'h00)
      clk_en <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(cfg_loaded, 1'b1)
      `CHK(active_cfg, {6'h1c, 2'h2})
      $display("freeze test done");
   endtask
   // Point-to-point mode leaves switches unused
   task t_p2p;
      load(8'hff, 1'b0, 2);
      `CHK(active_cfg, {`NVM_ADDR_RST, `NVM_RATE_RST})
      `CHK(multi_drop, 1'b0)
      $display("p2p test done");
   endtask
   // Safety inputs, disable bit, unmapped access
   task t_sto;
      sto_in1 <= 1'b1; sto_in2 <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(drive_enable, 1'b1)
      sto_in2 <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(drive_enable, 1'b0)
      apb(1'b1, `REG_CTRL_OFS, 32'h1);
      repeat (3) @(posedge clk);
      `CHK(drive_enable, 1'b1)
      apb(1'b0, 12'h030, 32'h0);
      `CHK({err, rdata}, 33'h100000000)
      $display("safety test done");
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard, well past the roughly 140 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      load(8'h00, 1'b1, 20);
      t_switch;
      t_zero;
      t_store;
      t_p2p;
      t_freeze;
      t_sto;
      wrap_up;
   end
endmodule
